// *** verilog/acr_consts.vh ***
// Constants for the accelerometer two-wire slave readout block.
// Functional notes
// - Start and stop are detected while clock high.
// - Bytes are eight bits, MSB first, then acknowledge.
// - Answer only address 0010 plus strapped bits.
// - Eighth address bit chooses read or write.
// - Acknowledge matched address and every written byte.
// - First written byte is the register index.
// - Control bit 0 requests sleep; clear wakes.
// - Control bit 1 enables the self check.
// - Control bit 2 enables the reference check.
// - Control bit 3 puts temperature on X positions.
// - Written index sets the read pointer.
// - Positions: control, X high, X low, Y high, Y low.
// - Index zero reads back the control register.
// - Pointer advances after each acknowledged read byte.
// - Positions 5 and 6 read zero, then wrap.
// - Samples are 12 or 10 bits wide.
// - Unused high bits of a sample read zero.
// - Data changes only while clock is low.
`ifndef ACR_CONSTS_VH
`define ACR_CONSTS_VH
`define ACR_ADDR_HIGH      4'h2
`define ACR_CTRL_RESET     8'h00
`define ACR_BIT_SLEEP      0
`define ACR_BIT_SELFCHK    1
`define ACR_BIT_REFCHK     2
`define ACR_BIT_THERMAL    3
`define ACR_IDX_CTRL       3'h0
`define ACR_IDX_XHIGH      3'h1
`define ACR_IDX_XLOW       3'h2
`define ACR_IDX_YHIGH      3'h3
`define ACR_IDX_YLOW       3'h4
`define ACR_IDX_LAST       3'h6
`define ACR_BITS_HIRES     12
`define ACR_BITS_LORES     10
`endif

// *** verilog/acr_i2c_slave.v ***
// Two-wire slave that exposes the control byte and the axis sample window.
`timescale 1ns/1ps
`default_nettype none
`include "acr_consts.vh"
module acr_i2c_slave (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        clockEnable,
  input  wire        sclIn,
  input  wire        sdaIn,
  output reg         sdaOut,
  output reg         sdaOe,
  input  wire [2:0]  addrStrap,
  input  wire        lowResMode,
  input  wire [11:0] xSample,
  input  wire [11:0] ySample,
  input  wire [11:0] thermalValue,
  output reg         sleepRequest,
  output reg         selfCheckEnable,
  output reg         referenceCheckEnable,
  output reg         thermalSelect
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_WIDX  = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_READ  = 3'h4;
  localparam ST_RACK  = 3'h5;
  localparam ST_SKIP  = 3'h6;

  reg  [2:0]  state_r;
  reg  [2:0]  ret_r;
  reg  [3:0]  bitCnt_r;
  reg  [7:0]  shift_r;
  reg  [7:0]  ctrl_r;
  reg  [2:0]  ptr_r;
  reg         ackPhase_r;
  reg         sclPrev_r;
  reg         sdaPrev_r;
  reg  [15:0] xSnap_r;
  reg  [15:0] ySnap_r;
  wire        sclRise;
  wire        sclFall;
  wire        startSeen;
  wire        stopSeen;
  wire [7:0]  curByte;

  assign sclRise   = sclIn & ~sclPrev_r;
  assign sclFall   = ~sclIn & sclPrev_r;
  assign startSeen = sclIn & sclPrev_r & sdaPrev_r & ~sdaIn;
  assign stopSeen  = sclIn & sclPrev_r & ~sdaPrev_r & sdaIn;

  // Masks a sample to the active resolution; the rest reads zero.
  function [15:0] fitSample;
    input [11:0] raw;
    input        low;
    begin
      if (low)
        fitSample = {6'h00, raw[9:0]};
      else
        fitSample = {4'h0, raw};
    end
  endfunction

  // Byte shown at a read position.
  function [7:0] readByte;
    input [2:0]  idx;
    input [7:0]  ctrl;
    input [15:0] xs;
    input [15:0] ys;
    begin
      case (idx)
        `ACR_IDX_CTRL:  readByte = ctrl;
        `ACR_IDX_XHIGH: readByte = xs[15:8];
        `ACR_IDX_XLOW:  readByte = xs[7:0];
        `ACR_IDX_YHIGH: readByte = ys[15:8];
        `ACR_IDX_YLOW:  readByte = ys[7:0];
        default:        readByte = 8'h00;
      endcase
    end
  endfunction

  // Byte at the read pointer: the live control register, or axis bytes from the snapshot taken at the read address.
  assign curByte = readByte(ptr_r, ctrl_r, xSnap_r, ySnap_r);

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      ret_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      ctrl_r <= `ACR_CTRL_RESET;
      ptr_r <= 3'h0;
      ackPhase_r <= 1'b0;
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
      xSnap_r <= 16'h0000;
      ySnap_r <= 16'h0000;
      sdaOut <= 1'b1;
      sdaOe <= 1'b0;
      sleepRequest <= 1'b0;
      selfCheckEnable <= 1'b0;
      referenceCheckEnable <= 1'b0;
      thermalSelect <= 1'b0;
    end else if (clockEnable) begin
      sclPrev_r <= sclIn;
      sdaPrev_r <= sdaIn;
      sleepRequest <= ctrl_r[`ACR_BIT_SLEEP];
      selfCheckEnable <= ctrl_r[`ACR_BIT_SELFCHK];
      referenceCheckEnable <= ctrl_r[`ACR_BIT_REFCHK];
      thermalSelect <= ctrl_r[`ACR_BIT_THERMAL];
      if (stopSeen) begin
        state_r <= ST_IDLE;
        sdaOe <= 1'b0;
        sdaOut <= 1'b1;
      end else if (startSeen) begin
        state_r <= ST_ADDR;
        bitCnt_r <= 4'h0;
        ackPhase_r <= 1'b0;
        sdaOe <= 1'b0;
        sdaOut <= 1'b1;
      end else begin
        case (state_r)
          ST_ADDR, ST_WIDX, ST_WDATA: begin
            if (!ackPhase_r && sclRise) begin
              shift_r <= {shift_r[6:0], sdaIn};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (!ackPhase_r && sclFall && bitCnt_r == 4'h8) begin
              ackPhase_r <= 1'b1;
              bitCnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                if (shift_r[7:1] == {`ACR_ADDR_HIGH, addrStrap}) begin
                  sdaOe <= 1'b1;
                  sdaOut <= 1'b0;
                  if (shift_r[0]) begin
                    ret_r <= ST_READ;
                    xSnap_r <= fitSample(ctrl_r[`ACR_BIT_THERMAL] ?
                                         thermalValue : xSample, lowResMode);
                    ySnap_r <= fitSample(ySample, lowResMode);
                  end else begin
                    ret_r <= ST_WIDX;
                  end
                end else begin
                  state_r <= ST_SKIP;
                end
              end else begin
                sdaOe <= 1'b1;
                sdaOut <= 1'b0;
                ret_r <= ST_WDATA;
                if (state_r == ST_WIDX) begin
                  ptr_r <= shift_r[2:0];
                end else if (ptr_r == `ACR_IDX_CTRL) begin
                  ctrl_r <= shift_r;
                end
              end
            end else if (ackPhase_r && sclFall) begin
              ackPhase_r <= 1'b0;
              state_r <= ret_r;
              if (ret_r == ST_READ) begin
                sdaOut <= curByte[7];
                sdaOe <= ~curByte[7];
                shift_r <= {curByte[6:0], 1'b0};
                bitCnt_r <= 4'h1;
              end else begin
                sdaOe <= 1'b0;
                sdaOut <= 1'b1;
              end
            end
          end
          ST_READ: begin
            if (sclFall) begin
              if (bitCnt_r == 4'h8) begin
                sdaOe <= 1'b0;
                sdaOut <= 1'b1;
                state_r <= ST_RACK;
              end else begin
                sdaOut <= shift_r[7];
                sdaOe <= ~shift_r[7];
                shift_r <= {shift_r[6:0], 1'b0};
                bitCnt_r <= bitCnt_r + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (sclRise) begin
              if (sdaIn) begin
                state_r <= ST_SKIP;
              end else begin
                ptr_r <= (ptr_r == `ACR_IDX_LAST) ? 3'h0 : ptr_r + 3'h1;
                ackPhase_r <= 1'b1;
                ret_r <= ST_READ;
                state_r <= ST_ADDR;
              end
            end
          end
          default: begin
            sdaOe <= 1'b0;
            sdaOut <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/acr_i2c_slave_monitor.sv ***
// Assertion checker for the two-wire slave readout block.
`timescale 1ns/1ps
`default_nettype none
module acr_i2c_slave_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clockEnable,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic sleepRequest,
  input wire logic selfCheckEnable,
  input wire logic referenceCheckEnable,
  input wire logic thermalSelect
);
  wire [3:0] ctl = {thermalSelect, referenceCheckEnable, selfCheckEnable, sleepRequest};
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  oe_level_a: assert property (sdaOut == !sdaOe)
    else $error("Data level disagrees with enable.");
  oe_edge_a: assert property ($changed(sdaOe) |-> !$past(sclIn))
    else $error("Data drive changed while clock high.");
  ctl_edge_a: assert property ($changed(ctl) |-> !$past(sclIn))
    else $error("Control changed while clock high.");
  ctl_ack_a: assert property ($changed(ctl) |-> ##[0:4] sdaOe)
    else $error("Control changed without an acknowledge.");
  drive_hold_a: assert property ($rose(sdaOe) |-> sdaOe[*4])
    else $error("Driven bit too short.");
  release_hold_a: assert property ($fell(sdaOe) |-> (!sdaOe)[*3])
    else $error("Released bit too short.");
  stop_idle_a: assert property (sclIn && $past(sclIn) && $rose(sdaIn) |=> (!sdaOe)[*4])
    else $error("Data driven after stop.");
  start_idle_a: assert property (sclIn && $past(sclIn) && $fell(sdaIn) |=> (!sdaOe)[*4])
    else $error("Data driven right after start.");
  freeze_hold_a: assert property (!clockEnable |=> $stable(sdaOe) && $stable(ctl))
    else $error("State moved while frozen.");
endmodule
bind acr_i2c_slave acr_i2c_slave_monitor mon (.*);
`default_nettype wire

// *** bench/acr_bus_master.sv ***
// Bus master model that clocks bytes to and from the slave.
`timescale 1ns/1ps
`default_nettype none
module acr_bus_master (
  input  wire logic clock,
  input  wire logic sdaWire,
  output var  logic scl,
  output var  logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic drv(input logic c, input logic d);
    scl = c;
    sda = d;
    repeat (4) @(posedge clock);
    #1;
  endtask
  task automatic bitx(input logic b, output logic r);
    drv(1'b0, b);
    drv(1'b1, b);
    r = sdaWire;
    drv(1'b0, b);
  endtask
  task automatic start();
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, k);
  endtask
  task automatic stop();
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
  endtask
endmodule
`default_nettype wire

// *** bench/acr_i2c_slave_tb.sv ***
// Self-checking bench for the two-wire slave readout block.
`timescale 1ns/1ps
`default_nettype none
`include "acr_consts.vh"
module acr_i2c_slave_tb;
  logic        clock, rst_b, clockEnable, lowResMode, sclIn, mSda;
  logic        sdaOut, sdaOe, sleepRequest, selfCheckEnable, referenceCheckEnable, thermalSelect;
  logic [2:0]  addrStrap;
  logic [11:0] xSample, ySample, thermalValue;
  logic [7:0]  ctrlV;
  int          errTotal = 0;
  int          testsRun = 0;
  wire         sdaWire = mSda & ~sdaOe;
  wire [7:0]   ctl = {4'h0, thermalSelect, referenceCheckEnable, selfCheckEnable, sleepRequest};
  acr_i2c_slave uut (
    .clock(clock), .rst_b(rst_b), .clockEnable(clockEnable), .sclIn(sclIn),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrap(addrStrap),
    .lowResMode(lowResMode), .xSample(xSample), .ySample(ySample),
    .thermalValue(thermalValue), .sleepRequest(sleepRequest),
    .selfCheckEnable(selfCheckEnable), .referenceCheckEnable(referenceCheckEnable),
    .thermalSelect(thermalSelect));
  acr_bus_master m (.clock(clock), .sdaWire(sdaWire), .scl(sclIn), .sda(mSda));
  task automatic finishTest();
    $display("Checks %0d, mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    testsRun++;
    if (got !== ex) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  function automatic logic [7:0] expB(input int i);
    logic [15:0] mk;
    logic [15:0] x;
    logic [15:0] y;
    mk = lowResMode ? 16'h03ff : 16'h0fff;
    x = {4'h0, ctrlV[`ACR_BIT_THERMAL] ? thermalValue : xSample} & mk;
    y = {4'h0, ySample} & mk;
    case (i % 7)
      0: return ctrlV;
      1: return x[15:8];
      2: return x[7:0];
      3: return y[15:8];
      4: return y[7:0];
      default: return 8'h00;
    endcase
  endfunction
  task automatic wrReg(input logic [2:0] s, input logic [7:0] ix, input logic [7:0] v,
                       input logic hit, input logic dat);
    logic [7:0] q;
    logic       a;
    m.start();
    m.xfer({`ACR_ADDR_HIGH, s, 1'b0}, 1'b1, q, a);
    chk("addrAck", {7'h0, !hit}, {7'h0, a});
    if (hit) m.xfer(ix, 1'b1, q, a);
    if (hit) chk("idxAck", 8'h00, {7'h0, a});
    if (hit && dat) m.xfer(v, 1'b1, q, a);
    if (hit && dat) chk("datAck", 8'h00, {7'h0, a});
    if (dat) m.stop();
    if (hit && dat && ix == 8'h00) ctrlV = v;
  endtask
  task automatic rdSeq(input int idx, input int n);
    logic [7:0] e [8];
    logic [7:0] q;
    logic       a;
    for (int k = 0; k < n; k++) e[k] = expB(idx + k);
    wrReg(addrStrap, 8'(idx), 8'h00, 1'b1, 1'b0);
    m.start();
    m.xfer({`ACR_ADDR_HIGH, addrStrap, 1'b1}, 1'b1, q, a);
    chk("rdAck", 8'h00, {7'h0, a});
    {xSample, ySample, thermalValue} = ~{xSample, ySample, thermalValue};
    for (int k = 0; k < n; k++) begin
      m.xfer(8'hff, k == n - 1, q, a);
      chk("rdByte", e[k], q);
    end
    m.stop();
  endtask
  task automatic scFull();
    wrReg(addrStrap, 8'h00, 8'h0e, 1'b1, 1'b1);
    chk("ctlOut", 8'h0e, ctl);
    // The wake delay is shortened to a few cycles; the slave has no timing of its own.
    repeat (16) @(posedge clock);
    #1;
    rdSeq(0, 8);
  endtask
  task automatic scLowRes();
    lowResMode = 1'b1;
    xSample = 12'h3a5;
    wrReg(addrStrap, 8'h00, 8'h01, 1'b1, 1'b1);
    chk("ctlOut", 8'h01, ctl);
    rdSeq(1, 4);
    rst_b = 1'b0;
    @(posedge clock);
    #1;
    rst_b = 1'b1;
    ctrlV = 8'h00;
    chk("ctlRst", 8'h00, ctl);
  endtask
  task automatic scRefuse();
    wrReg(3'h2, 8'h00, 8'h0f, 1'b0, 1'b1);
    wrReg(addrStrap, 8'h02, 8'h0f, 1'b1, 1'b1);
    clockEnable = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    clockEnable = 1'b1;
    chk("ctlKeep", 8'h00, ctl);
    rdSeq(0, 1);
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    rst_b = 1'b0;
    clockEnable = 1'b1;
    lowResMode = 1'b0;
    addrStrap = 3'h5;
    xSample = 12'h9c3;
    ySample = 12'h801;
    thermalValue = 12'h4d7;
    ctrlV = 8'h00;
    repeat (6) @(posedge clock);
    #1;
    rst_b = 1'b1;
    scFull();
    scLowRes();
    scRefuse();
    finishTest();
  end
  initial begin
    repeat (60000) @(posedge clock);
    errTotal++;
    finishTest();
  end
endmodule
`default_nettype wire
